/* File: rtl/lst_pkg.sv */
// Package with constants and types for the load self-test sequencer.
package lst_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LOAD_ON_S = 15;
  localparam int unsigned PAUSE_S = 2;
  localparam int unsigned COMP_MIN = 5;
  localparam int unsigned COMP_S = COMP_MIN * 60;
  localparam int unsigned DAMP_PHASE_S = 5;
  localparam int unsigned SEC_W = 9;
  localparam int unsigned NLOAD = 7;
  localparam logic [3:0] FW_VERSION = 4'h4;
  localparam logic [2:0] LD_AUXA = 3'h0;
  localparam logic [2:0] LD_FANA = 3'h1;
  localparam logic [2:0] LD_FANB = 3'h2;
  localparam logic [2:0] LD_DMPA = 3'h3;
  localparam logic [2:0] LD_DMPB = 3'h4;
  localparam logic [2:0] LD_AUXB = 3'h5;
  localparam logic [2:0] LD_AUXC = 3'h6;

  typedef enum logic [2:0] {
    LST_IDLE, LST_ON, LST_DMP_CLOSE1, LST_DMP_OPEN, LST_DMP_CLOSE2, LST_PAUSE, LST_COMP
  } lst_state_t;

  typedef struct packed {
    logic power;
    logic lock;
    logic plus;
  } lst_keys_t;

  typedef struct packed {
    logic [NLOAD-1:0] load;
    logic damper_close;
    logic comp;
    logic cond_fan;
  } lst_drive_t;
endpackage : lst_pkg

/* File: rtl/lst_sec_tick.sv */
// Prescaler making a one-cycle pulse once per second.
`timescale 1ns/10ps
`default_nettype none
module lst_sec_tick #(
  parameter int unsigned DIV = lst_pkg::CLK_HZ
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lst_tick_st_t;
  lst_tick_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (clr || st_r.cnt == DIV - 1) begin
      st_nxt.cnt = 32'h0;
      st_nxt.tick = !clr;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : lst_sec_tick
`default_nettype wire

/* File: rtl/lst_seq.sv */
// Load self-test sequencer top module.
`timescale 1ns/10ps
`default_nettype none
module lst_seq #(
  parameter int unsigned SEC_DIV = lst_pkg::CLK_HZ,
  parameter bit DUAL_ZONE = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire lst_pkg::lst_keys_t keys_pin,
  input wire logic cool_call,
  input wire logic [3:0] temp_digit,
  output lst_pkg::lst_drive_t drive,
  output logic test_active,
  output logic unit_on,
  output logic [3:0] disp_digit,
  output logic disp_version
);
  typedef struct packed {
    lst_pkg::lst_keys_t k1;
    lst_pkg::lst_keys_t k2;
    lst_pkg::lst_keys_t kp;
    lst_pkg::lst_state_t st;
    logic [2:0] idx;
    logic [lst_pkg::SEC_W-1:0] secs;
    logic manual;
    logic por_pend;
    logic off_pend;
    logic unit_on;
    lst_pkg::lst_drive_t drv;
    logic [3:0] digit;
    logic ver;
  } lst_st_t;
  lst_st_t s_r, s_nxt;
  logic sec;
  logic reload;

  // Reloading the prescaler with the seconds counter keeps every step a whole number of seconds long.
  lst_sec_tick #(.DIV(SEC_DIV)) u_tick (
    .mclk(mclk),
    .rst(rst),
    .clr(reload),
    .tick(sec)
  );

  function automatic logic present(input logic [2:0] i, input bit dual);
    present = dual || i == lst_pkg::LD_AUXA || i == lst_pkg::LD_FANB || i == lst_pkg::LD_AUXC;
  endfunction : present

  function automatic logic [2:0] next_idx(input logic [2:0] i, input bit dual);
    logic [2:0] j;
    j = i + 3'h1;
    while (j < 3'(lst_pkg::NLOAD) && !present(j, dual)) begin
      j = j + 3'h1;
    end
    next_idx = j;
  endfunction : next_idx

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic done;
    logic pwr_edge;
    logic is_damper;
    s_nxt = s_r;
    reload = 1'b0;
    s_nxt.k1 = keys_pin;
    s_nxt.k2 = s_r.k1;
    s_nxt.kp = s_r.k2;
    pwr_edge = s_r.k2.power && !s_r.kp.power;
    // Ending a step on its last tick keeps each step at whole seconds, not seconds plus one cycle.
    done = s_r.secs == '0 || (sec && s_r.secs - 1'b1 == '0);
    is_damper = s_r.idx == lst_pkg::LD_DMPA || s_r.idx == lst_pkg::LD_DMPB;
    if (sec && !done) begin
      s_nxt.secs = s_r.secs - 1'b1;
    end
    if (pwr_edge) begin
      if (s_r.st != lst_pkg::LST_IDLE && s_r.unit_on) begin
        s_nxt.off_pend = !s_r.off_pend;
      end else begin
        s_nxt.unit_on = !s_r.unit_on;
      end
    end
    s_nxt.drv.load = '0;
    s_nxt.drv.damper_close = 1'b0;
    s_nxt.drv.comp = s_r.unit_on && cool_call;
    s_nxt.drv.cond_fan = s_r.unit_on && cool_call;
    case (s_r.st)
      lst_pkg::LST_IDLE: begin
        if (s_r.por_pend || (s_r.k2.lock && s_r.k2.plus)) begin
          s_nxt.manual = !s_r.por_pend;
          s_nxt.por_pend = 1'b0;
          s_nxt.idx = lst_pkg::LD_AUXA;
          s_nxt.st = lst_pkg::LST_ON;
          s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::LOAD_ON_S);
          reload = 1'b1;
        end
      end
      lst_pkg::LST_ON: begin
        s_nxt.drv.comp = 1'b0;
        s_nxt.drv.cond_fan = 1'b0;
        if (is_damper) begin
          s_nxt.drv.load[s_r.idx] = 1'b1;
          s_nxt.drv.damper_close = 1'b1;
          s_nxt.st = lst_pkg::LST_DMP_CLOSE1;
          s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::DAMP_PHASE_S);
          reload = 1'b1;
        end else if (done) begin
          s_nxt.st = lst_pkg::LST_PAUSE;
          s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::PAUSE_S);
          reload = 1'b1;
        end else begin
          s_nxt.drv.load[s_r.idx] = 1'b1;
        end
      end
      lst_pkg::LST_DMP_CLOSE1, lst_pkg::LST_DMP_OPEN, lst_pkg::LST_DMP_CLOSE2: begin
        s_nxt.drv.comp = 1'b0;
        s_nxt.drv.cond_fan = 1'b0;
        // The damper stays energized across phase changes, and the prescaler runs on freely
        // inside one damper step, so the three phases add no extra cycles.
        s_nxt.drv.load[s_r.idx] = 1'b1;
        s_nxt.drv.damper_close = s_r.st != lst_pkg::LST_DMP_OPEN;
        if (done) begin
          s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::DAMP_PHASE_S);
          if (s_r.st == lst_pkg::LST_DMP_CLOSE1) begin
            s_nxt.st = lst_pkg::LST_DMP_OPEN;
            s_nxt.drv.damper_close = 1'b0;
          end else if (s_r.st == lst_pkg::LST_DMP_OPEN) begin
            s_nxt.st = lst_pkg::LST_DMP_CLOSE2;
            s_nxt.drv.damper_close = 1'b1;
          end else begin
            s_nxt.st = lst_pkg::LST_PAUSE;
            s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::PAUSE_S);
            s_nxt.drv.load = '0;
            s_nxt.drv.damper_close = 1'b0;
            reload = 1'b1;
          end
        end
      end
      lst_pkg::LST_PAUSE: begin
        s_nxt.drv.comp = 1'b0;
        s_nxt.drv.cond_fan = 1'b0;
        if (done) begin
          reload = 1'b1;
          if (next_idx(s_r.idx, DUAL_ZONE) >= 3'(lst_pkg::NLOAD)) begin
            s_nxt.st = lst_pkg::LST_COMP;
            s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::COMP_S);
          end else begin
            s_nxt.idx = next_idx(s_r.idx, DUAL_ZONE);
            s_nxt.st = lst_pkg::LST_ON;
            s_nxt.secs = lst_pkg::SEC_W'(lst_pkg::LOAD_ON_S);
          end
        end
      end
      lst_pkg::LST_COMP: begin
        s_nxt.drv.comp = 1'b1;
        s_nxt.drv.cond_fan = 1'b1;
        if (done) begin
          s_nxt.st = lst_pkg::LST_IDLE;
          s_nxt.manual = 1'b0;
          s_nxt.drv.comp = s_r.unit_on && !s_r.off_pend && cool_call;
          s_nxt.drv.cond_fan = s_r.unit_on && !s_r.off_pend && cool_call;
          if (s_r.off_pend) begin
            s_nxt.unit_on = 1'b0;
            s_nxt.off_pend = 1'b0;
          end
        end
      end
      default: s_nxt.st = lst_pkg::LST_IDLE;
    endcase
    // A hidden test keeps normal display; only manual or key request shows the version.
    s_nxt.ver = s_nxt.st != lst_pkg::LST_IDLE
      && (s_nxt.manual || (s_r.k2.power && s_r.k2.lock));
    s_nxt.digit = s_nxt.ver ? lst_pkg::FW_VERSION : temp_digit;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= lst_pkg::LST_IDLE;
      s_r.por_pend <= 1'b1;
      s_r.unit_on <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign drive = s_r.drv;
  assign test_active = s_r.st != lst_pkg::LST_IDLE;
  assign unit_on = s_r.unit_on;
  assign disp_digit = s_r.digit;
  assign disp_version = s_r.ver;

  ////////////////////////////////////////////////////////////////////////////
  one_load_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(s_r.drv.load)) else $error("two loads on at once");
  load_gap_a: assert property (@(posedge mclk) disable iff (rst)
    (s_r.drv.load != '0 && s_nxt.drv.load != '0) |-> s_nxt.drv.load == s_r.drv.load)
    else $error("load switched without gap");
  comp_alone_a: assert property (@(posedge mclk) disable iff (rst)
    s_r.drv.load != '0 |-> !s_r.drv.comp) else $error("compressor with load");
  por_start_a: assert property (@(posedge mclk) $fell(rst) |-> ##[1:2] test_active)
    else $error("no test after reset");
  off_hold_a: assert property (@(posedge mclk) disable iff (rst)
    test_active && $past(unit_on) |-> unit_on) else $error("unit off during test");
  manual_ver_a: assert property (@(posedge mclk) disable iff (rst)
    test_active && s_r.manual |-> disp_digit == lst_pkg::FW_VERSION)
    else $error("version not shown in manual test");
  manual_ign_a: assert property (@(posedge mclk) disable iff (rst)
    test_active && !s_r.manual |=> !s_r.manual) else $error("manual restart");
  comp_end_a: assert property (@(posedge mclk) disable iff (rst)
    s_r.st == lst_pkg::LST_COMP && sec && s_r.secs == lst_pkg::SEC_W'(1) && unit_on
    && !s_r.off_pend && cool_call
    |=> s_r.drv.comp && s_r.drv.cond_fan) else $error("compressor dropped");
  damp_c: cover property (@(posedge mclk) s_r.st == lst_pkg::LST_DMP_OPEN);
  comp_c: cover property (@(posedge mclk) s_r.st == lst_pkg::LST_COMP);
  manual_c: cover property (@(posedge mclk) test_active && s_r.manual);
endmodule : lst_seq
`default_nettype wire

/* File: dv/lst_load_model.sv */
// Load side model that times every load the sequencer drives during a test.
`timescale 1ns/10ps
`default_nettype none
module lst_load_model #(
  parameter int unsigned SEC = 10,
  parameter bit DUAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire lst_pkg::lst_drive_t drive,
  input wire logic test_active,
  output int errs,
  output int steps
);
  int on_n;
  int off_n;
  int cl_n;
  logic [7:0] prev;
  logic ta_prev;
  function automatic bit near(input int a, input int b);
    return a >= b - 2 && a <= b + 2;
  endfunction : near
  // Timing is judged at edges only, so one slow step costs one count rather than thousands.
  always @(posedge mclk) begin
    int e;
    bit dmp;
    e = 0;
    dmp = prev[3] | prev[4];
    prev <= {drive.comp, drive.load};
    ta_prev <= test_active;
    on_n <= on_n + 1;
    off_n <= off_n + 1;
    cl_n <= cl_n + drive.damper_close;
    if ($countones({drive.load, drive.comp & test_active}) > 1) e++;
    if (drive.load == '0 && drive.damper_close) e++;
    if (test_active && !ta_prev) begin
      steps <= 0;
    end else if (prev[6:0] == '0 && drive.load != '0) begin
      on_n <= 1;
      cl_n <= drive.damper_close;
      if (drive.load != 7'h01 << (DUAL ? steps : steps * steps + steps)) e++;
      if (steps > 0 && !near(off_n, lst_pkg::PAUSE_S * SEC)) e++;
    end else if (prev[6:0] != '0 && drive.load == '0) begin
      off_n <= 1;
      steps <= steps + 1;
      if (dmp && !near(cl_n, 2 * lst_pkg::DAMP_PHASE_S * SEC)) e++;
      if (!near(on_n, (dmp ? 3 * lst_pkg::DAMP_PHASE_S : lst_pkg::LOAD_ON_S) * SEC)) e++;
    end else if (drive.comp && !prev[7] && test_active) begin
      on_n <= 1;
      if (steps != (DUAL ? 7 : 3) || !near(off_n, lst_pkg::PAUSE_S * SEC)) e++;
    end else if (!test_active && ta_prev) begin
      steps <= steps + 1;
      if (!near(on_n, lst_pkg::COMP_S * SEC)) e++;
    end
    errs <= rst ? 0 : errs + e;
  end
endmodule : lst_load_model
`default_nettype wire

/* File: dv/tb_lst_seq.sv */
// Self-checking bench running dual and single zone sequencers side by side.
`timescale 1ns/10ps
`default_nettype none
module tb_lst_seq;
  localparam int unsigned SEC = 10;
  logic mclk;
  logic rst;
  lst_pkg::lst_keys_t keys;
  logic cool_call;
  logic [3:0] temp_digit;
  lst_pkg::lst_drive_t drive;
  lst_pkg::lst_drive_t drive_sz;
  logic test_active;
  logic ta_sz;
  logic unit_on;
  logic on_sz;
  logic [3:0] disp_digit;
  logic disp_version;
  int errs;
  int steps;
  int errs_sz;
  int steps_sz;
  int fails = 0;
  int tests_run = 0;
  int ver_miss = 0;
  bit chk_disp = 1'b0;
  bit watch_ver = 1'b0;
  logic [31:0] seed = 32'h333A;
  lst_seq #(.SEC_DIV(SEC), .DUAL_ZONE(1'b1)) i_lst_seq (.mclk(mclk), .rst(rst),
    .keys_pin(keys), .cool_call(cool_call), .temp_digit(temp_digit), .drive(drive),
    .test_active(test_active), .unit_on(unit_on), .disp_digit(disp_digit),
    .disp_version(disp_version));
  lst_seq #(.SEC_DIV(SEC), .DUAL_ZONE(1'b0)) i_lst_seq_sz (.mclk(mclk), .rst(rst),
    .keys_pin(keys), .cool_call(cool_call), .temp_digit(temp_digit), .drive(drive_sz),
    .test_active(ta_sz), .unit_on(on_sz), .disp_digit(), .disp_version());
  lst_load_model #(.SEC(SEC), .DUAL(1'b1)) i_lst_load_model (.mclk(mclk), .rst(rst),
    .drive(drive), .test_active(test_active), .errs(errs), .steps(steps));
  lst_load_model #(.SEC(SEC), .DUAL(1'b0)) i_lst_load_model_sz (.mclk(mclk), .rst(rst),
    .drive(drive_sz), .test_active(ta_sz), .errs(errs_sz), .steps(steps_sz));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // Every input change lands at the falling edge, half a period clear of sampling.
  task automatic step(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge mclk);
      if (chk_disp && disp_version === 1'b0) check("disp_digit", temp_digit, disp_digit);
      if (watch_ver && test_active === 1'b1 && disp_version !== 1'b1) ver_miss++;
      seed = xs(seed);
      temp_digit = seed[3:0];
    end
  endtask : step
  task automatic press(input logic [2:0] k);
    keys = k;
    step(5);
    keys = 3'h0;
    step(6);
  endtask : press
  task automatic wait_end();
    int k;
    k = 0;
    while (test_active !== 1'b0 && k < 8000) begin
      step(1);
      k++;
    end
    if (k == 8000) begin
      fails++;
      stop_test();
    end
  endtask : wait_end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    keys = 3'h0;
    cool_call = 1'b0;
    temp_digit = 4'h0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    step(5);
    check("test_active", 1, test_active);
    check("ta_sz", 1, ta_sz);
    check("disp_version", 0, disp_version);
    chk_disp = 1'b1;
    step(40);
    keys = 3'h6;
    step(10);
    check("disp_version", 1, disp_version);
    check("disp_digit", lst_pkg::FW_VERSION, disp_digit);
    keys = 3'h0;
    step(20);
    check("unit_on", 1, unit_on);
    wait_end();
    chk_disp = 1'b0;
    step(1);
    check("unit_on", 0, unit_on);
    check("on_sz", 0, on_sz);
    check("errs", 0, errs + errs_sz);
    check("steps", 8, steps);
    check("steps_sz", 4, steps_sz);
    $display("test por_sequence done");
    press(3'h4);
    check("unit_on", 1, unit_on);
    press(3'h3);
    check("test_active", 1, test_active);
    check("disp_digit", lst_pkg::FW_VERSION, disp_digit);
    cool_call = 1'b1;
    watch_ver = 1'b1;
    step(500);
    press(3'h3);
    wait_end();
    watch_ver = 1'b0;
    step(1);
    check("ver_miss", 0, ver_miss);
    check("errs", 0, errs + errs_sz);
    check("steps", 8, steps);
    check("steps_sz", 4, steps_sz);
    check("comp", 1, drive.comp);
    check("cond_fan", 1, drive.cond_fan);
    check("disp_version", 0, disp_version);
    cool_call = 1'b0;
    step(3);
    check("comp", 0, drive.comp);
    $display("test manual_sequence done");
    stop_test();
  end
endmodule : tb_lst_seq
`default_nettype wire
